/* hw/handler_port_pkg.sv */
package handler_port_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] LOWC_OFF     = 8'h04;
  localparam logic [7:0] STATUS_OFF   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] RESULT_OFF   = 8'h14;

  // Widths and field positions.
  localparam int CTRL_W      = 3;
  localparam int PCT_W       = 7;
  localparam int IRQ_W       = 5;
  localparam int CLASS_COUNT = 11;
  localparam int KEY_W       = 8;
  localparam int NO_MATCH_IX = 9;
  localparam int AUX_IX      = 10;
  localparam int PCT_SCALE   = 100;
  localparam int IRQ_ANALOG  = 0;
  localparam int IRQ_CYCLE   = 1;
  localparam int IRQ_TRIG    = 2;
  localparam int IRQ_MISS    = 3;
  localparam int IRQ_OVER    = 4;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [PCT_W-1:0]  LOWC_RESET = 7'h00;
  localparam logic [IRQ_W-1:0]  MASK_RESET = 5'h00;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_MEASURE = 3'b010,
    ST_CALC    = 3'b100
  } meas_state_t;

  // Bit 0 enables the comparator, bit 1 selects external trigger,
  // bit 2 routes secondary rejects to the auxiliary class.
  typedef struct packed {
    logic aux_en;
    logic ext_mode;
    logic comp_en;
  } ctrl_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [3:0] bin;
    logic       prim_low;
    logic       prim_high;
    logic       sec_out;
    logic       overload;
    logic       no_contact;
  } meas_result_t;

  typedef struct packed {
    logic [CLASS_COUNT-1:0] class_hit;
    logic                   above;
    logic                   below;
    logic                   sec_rej;
    logic                   over;
  } sort_t;

  typedef struct packed {
    meas_state_t            st;
    ctrl_t                  ctrl;
    logic [PCT_W-1:0]       lowc_pct;
    logic [IRQ_W-1:0]       irq_stat;
    logic [IRQ_W-1:0]       irq_mask;
    logic                   trig_prev;
    logic                   have_result;
    logic [CLASS_COUNT-1:0] class_n;
    logic [CLASS_COUNT-1:0] sink;
    logic                   above_n;
    logic                   below_n;
    logic                   sec_n;
    logic                   lowc_n;
    logic                   over_n;
    logic                   ready_n;
    logic                   analog_done_n;
    logic                   cycle_n;
    logic                   start;
    logic [KEY_W-1:0]       keys;
    logic                   irq;
    apb_rsp_t               rsp;
  } port_state_t;

  localparam port_state_t STATE_RESET = '{
    st:       ST_IDLE,
    ctrl:     ctrl_t'(CTRL_RESET),
    lowc_pct: LOWC_RESET,
    irq_mask: MASK_RESET,
    class_n:  {CLASS_COUNT{1'b1}},
    above_n:  1'b1,
    below_n:  1'b1,
    sec_n:    1'b1,
    lowc_n:   1'b1,
    over_n:   1'b1,
    ready_n:  1'b1,
    default:  '0
  };

endpackage

/* hw/sort_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

module sort_decoder (
  input  wire handler_port_pkg::meas_result_t res_in,    // Measurement result
  input  wire logic                           aux_en_in, // Aux class enable
  output handler_port_pkg::sort_t             sort_out   // Decoded lines
);

  // Exactly one class bit is set on every path, so once a result is taken
  // with the comparator on, the handler sees a single class line.
  always_comb begin
    sort_out = '0;
    if (res_in.overload || res_in.no_contact) begin
      sort_out.class_hit[handler_port_pkg::NO_MATCH_IX] = 1'b1;
      sort_out.over = res_in.overload;
    end else if (res_in.prim_low) begin
      sort_out.class_hit[handler_port_pkg::NO_MATCH_IX] = 1'b1;
      sort_out.below = 1'b1;
    end else if (res_in.prim_high) begin
      sort_out.class_hit[handler_port_pkg::NO_MATCH_IX] = 1'b1;
      sort_out.above = 1'b1;
    end else if (res_in.bin >= 4'h1 && res_in.bin <= 4'h9) begin
      if (res_in.sec_out) begin
        sort_out.sec_rej = 1'b1;
        if (aux_en_in) begin
          sort_out.class_hit[handler_port_pkg::AUX_IX] = 1'b1;
        end else begin
          sort_out.class_hit[handler_port_pkg::NO_MATCH_IX] = 1'b1;
        end
      end else begin
        sort_out.class_hit[res_in.bin - 4'h1] = 1'b1;
      end
    end else begin
      // A bin code outside 1..9 cannot be placed in any class.
      sort_out.class_hit[handler_port_pkg::NO_MATCH_IX] = 1'b1;
    end
  end

endmodule

`default_nettype wire

/* hw/handler_port.sv */
// Notes on behaviour
// - Port lines named as active low assert when low, rest high.
// - Exactly one of eleven class lines asserted, each an open-collector sink; none before the first result with the comparator on.
// - In external trigger mode a rising trigger edge starts a measurement.
// - Primary above the class limits drives the above-limit flag low.
// - Primary below the class limits drives the below-limit flag low.
// - Secondary outside its limit drives the secondary flag low.
// - Trigger-acceptable is low while a new trigger can be taken.
// - Internal trigger mode never asserts trigger-acceptable.
// - Capacitance at or below the percent threshold drives low-value flag.
// - The no-contact result also drives the low-value flag low.
// - Overload drives the overrange flag low.
// - Panel key presses are dropped while the lockout input is low.
// - Comparator off: no sort or flag lines, done lines held low.
// - Analog-done asserts when the analog phase ends.
// - Cycle-complete asserts only once results and class lines are valid.
//
// Decided for this implementation: the APB slave port and the address map.

`timescale 1ns/10ps
`default_nettype none

module handler_port #(
  parameter int VALUE_W = 24  // Width of capacitance value and range
) (
  input  wire logic                           core_clk_in,      // Clock
  input  wire logic                           reset_in,         // Sync reset
  input  wire handler_port_pkg::apb_req_t     apb_req_in,       // APB request
  output handler_port_pkg::apb_rsp_t          apb_rsp_out,      // APB answer
  input  wire logic                           external_trigger_in, // Trigger
  input  wire logic                           key_lock_n_in,    // Lockout
  input  wire logic [handler_port_pkg::KEY_W-1:0] panel_keys_in, // Keys
  output logic [handler_port_pkg::KEY_W-1:0]  panel_keys_out,   // Gated keys
  input  wire logic                           analog_done_in,   // Analog end
  input  wire logic                           result_valid_in,  // Result ok
  input  wire handler_port_pkg::meas_result_t result_in,        // Result
  input  wire logic [VALUE_W-1:0]             measured_value_in, // Cp or Cs
  input  wire logic [VALUE_W-1:0]             range_full_in,    // Range top
  output logic                                measure_start_out, // Start
  output logic [handler_port_pkg::CLASS_COUNT-1:0] class_line_n_out, // Class
  output logic [handler_port_pkg::CLASS_COUNT-1:0] class_sink_out, // Sink on
  output logic                                primary_above_limit_n_out, // Hi
  output logic                                primary_below_limit_n_out, // Lo
  output logic                                secondary_out_of_limit_n_out,
  output logic                                trigger_acceptable_n_out, // Rdy
  output logic                                low_value_or_open_contact_n_out,
  output logic                                measurement_overrange_n_out,
  output logic                                analog_done_n_out, // Analog end
  output logic                                cycle_complete_n_out, // Done
  output logic                                irq_out           // Interrupt
);

  localparam int PROD_W = VALUE_W + handler_port_pkg::PCT_W;

  handler_port_pkg::port_state_t r;
  handler_port_pkg::port_state_t next_r;
  handler_port_pkg::sort_t       sort;
  logic [PROD_W-1:0]             value_scaled;
  logic [PROD_W-1:0]             limit_scaled;
  logic                          lowc_hit;
  logic                          trig_edge;
  logic                          setup_phase;
  logic                          access_done;
  logic                          accept_result;

  sort_decoder u_sort_decoder (
    .res_in    (result_in),
    .aux_en_in (r.ctrl.aux_en),
    .sort_out  (sort)
  );

  // Comparing value*100 against range*percent avoids a divider.
  assign value_scaled = PROD_W'(measured_value_in)
                        * PROD_W'(handler_port_pkg::PCT_SCALE);
  assign limit_scaled = PROD_W'(range_full_in) * PROD_W'(r.lowc_pct);
  assign lowc_hit     = (value_scaled <= limit_scaled);

  assign trig_edge     = external_trigger_in & ~r.trig_prev;
  assign setup_phase   = apb_req_in.psel & ~apb_req_in.penable;
  assign access_done   = apb_req_in.psel & apb_req_in.penable & r.rsp.pready;
  assign accept_result = result_valid_in & (r.st != handler_port_pkg::ST_IDLE);

  always_comb begin
    logic [handler_port_pkg::IRQ_W-1:0] irq_set;
    logic [handler_port_pkg::IRQ_W-1:0] irq_clr;
    irq_set = '0;
    irq_clr = '0;
    next_r  = r;
    next_r.start       = 1'b0;
    next_r.rsp.pready  = 1'b0;
    next_r.rsp.pslverr = 1'b0;
    next_r.trig_prev   = external_trigger_in;

    // Register writes take effect at the completing access edge.
    if (access_done && apb_req_in.pwrite) begin
      unique case (apb_req_in.paddr)
        handler_port_pkg::CTRL_OFF: begin
          next_r.ctrl = handler_port_pkg::ctrl_t'(
            apb_req_in.pwdata[handler_port_pkg::CTRL_W-1:0]);
        end
        handler_port_pkg::LOWC_OFF: begin
          next_r.lowc_pct = apb_req_in.pwdata[handler_port_pkg::PCT_W-1:0];
        end
        handler_port_pkg::IRQ_STAT_OFF: begin
          irq_clr = apb_req_in.pwdata[handler_port_pkg::IRQ_W-1:0];
        end
        handler_port_pkg::IRQ_MASK_OFF: begin
          next_r.irq_mask = apb_req_in.pwdata[handler_port_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // The answer is prepared in the setup cycle so that pready comes
    // from a flop and every access completes with no wait state.
    if (setup_phase) begin
      next_r.rsp.pready = 1'b1;
      next_r.rsp.prdata = '0;
      unique case (apb_req_in.paddr)
        handler_port_pkg::CTRL_OFF: begin
          next_r.rsp.prdata[handler_port_pkg::CTRL_W-1:0] = r.ctrl;
        end
        handler_port_pkg::LOWC_OFF: begin
          next_r.rsp.prdata[handler_port_pkg::PCT_W-1:0] = r.lowc_pct;
        end
        handler_port_pkg::STATUS_OFF: begin
          next_r.rsp.prdata[7:0] = {r.st, r.have_result, ~r.ready_n,
                                    ~r.analog_done_n, ~r.cycle_n,
                                    external_trigger_in};
        end
        handler_port_pkg::IRQ_STAT_OFF: begin
          next_r.rsp.prdata[handler_port_pkg::IRQ_W-1:0] = r.irq_stat;
        end
        handler_port_pkg::IRQ_MASK_OFF: begin
          next_r.rsp.prdata[handler_port_pkg::IRQ_W-1:0] = r.irq_mask;
        end
        handler_port_pkg::RESULT_OFF: begin
          next_r.rsp.prdata[15:0] = {~r.over_n, ~r.lowc_n, ~r.sec_n,
                                     ~r.below_n, ~r.above_n, r.sink};
        end
        default: begin
          next_r.rsp.pslverr = 1'b1;
        end
      endcase
    end

    unique case (r.st)
      handler_port_pkg::ST_IDLE: begin
        // Internal mode restarts at once; external waits for an edge.
        if (r.ctrl.ext_mode ? trig_edge : 1'b1) begin
          next_r.start = 1'b1;
          next_r.st    = handler_port_pkg::ST_MEASURE;
          next_r.analog_done_n = 1'b1;
          next_r.cycle_n       = 1'b1;
          irq_set[handler_port_pkg::IRQ_TRIG] = r.ctrl.ext_mode;
        end
      end
      handler_port_pkg::ST_MEASURE: begin
        irq_set[handler_port_pkg::IRQ_MISS] = trig_edge & r.ctrl.ext_mode;
        if (analog_done_in || result_valid_in) begin
          next_r.st = handler_port_pkg::ST_CALC;
          next_r.analog_done_n = 1'b0;
          irq_set[handler_port_pkg::IRQ_ANALOG] = 1'b1;
        end
      end
      handler_port_pkg::ST_CALC: begin
        irq_set[handler_port_pkg::IRQ_MISS] = trig_edge & r.ctrl.ext_mode;
      end
    endcase

    // Every sort and flag line is loaded in the same cycle and then left
    // alone, so the handler never samples a half-updated set.
    if (accept_result) begin
      next_r.st          = handler_port_pkg::ST_IDLE;
      next_r.analog_done_n = 1'b0;
      next_r.cycle_n     = 1'b0;
      next_r.have_result = 1'b1;
      next_r.class_n     = ~sort.class_hit;
      next_r.sink        = sort.class_hit;
      next_r.above_n     = ~sort.above;
      next_r.below_n     = ~sort.below;
      next_r.sec_n       = ~sort.sec_rej;
      next_r.over_n      = ~sort.over;
      next_r.lowc_n      = ~(result_in.no_contact | lowc_hit);
      irq_set[handler_port_pkg::IRQ_CYCLE] = 1'b1;
      irq_set[handler_port_pkg::IRQ_OVER]  = result_in.overload;
      if (!r.ctrl.ext_mode) begin
        next_r.st = handler_port_pkg::ST_IDLE;
      end
    end

    if (!next_r.ctrl.comp_en) begin
      next_r.class_n       = '1;
      next_r.sink          = '0;
      next_r.above_n       = 1'b1;
      next_r.below_n       = 1'b1;
      next_r.sec_n         = 1'b1;
      next_r.lowc_n        = 1'b1;
      next_r.over_n        = 1'b1;
      next_r.analog_done_n = 1'b0;
      next_r.cycle_n       = 1'b0;
      next_r.have_result   = 1'b0;
    end else if (!r.ctrl.comp_en) begin
      // Fresh enable: no result is valid yet, so done lines go high.
      next_r.analog_done_n = 1'b1;
      next_r.cycle_n       = 1'b1;
    end

    next_r.ready_n = ~(next_r.ctrl.comp_en & next_r.ctrl.ext_mode
                       & (next_r.st == handler_port_pkg::ST_IDLE));

    next_r.keys = key_lock_n_in ? panel_keys_in : '0;

    // A new event in the clearing cycle survives the write of one.
    next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
    next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      r <= handler_port_pkg::STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign apb_rsp_out                     = r.rsp;
  assign panel_keys_out                  = r.keys;
  assign measure_start_out               = r.start;
  assign class_line_n_out                = r.class_n;
  assign class_sink_out                  = r.sink;
  assign primary_above_limit_n_out       = r.above_n;
  assign primary_below_limit_n_out       = r.below_n;
  assign secondary_out_of_limit_n_out    = r.sec_n;
  assign trigger_acceptable_n_out        = r.ready_n;
  assign low_value_or_open_contact_n_out = r.lowc_n;
  assign measurement_overrange_n_out     = r.over_n;
  assign analog_done_n_out               = r.analog_done_n;
  assign cycle_complete_n_out            = r.cycle_n;
  assign irq_out                         = r.irq;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  chk_sink_polarity :
  assert property (class_sink_out == ~class_line_n_out)
    else $error("class sink does not mirror low class line");

  chk_one_class_line :
  assert property (r.have_result |-> $onehot(class_sink_out))
    else $error("not exactly one class line asserted");

  chk_external_trigger_in_start :
  assert property ((r.st == handler_port_pkg::ST_IDLE) && r.ctrl.ext_mode
                   && $rose(external_trigger_in)
                   |=> measure_start_out ##1 !measure_start_out)
    else $error("trigger edge did not start one measurement");

  chk_above_flag :
  assert property ((accept_result && result_in.prim_high
                    && !result_in.prim_low && !result_in.overload
                    && !result_in.no_contact) ##1 r.ctrl.comp_en
                   |-> !primary_above_limit_n_out)
    else $error("above-limit flag not asserted");

  chk_below_flag :
  assert property ((accept_result && result_in.prim_low
                    && !result_in.overload && !result_in.no_contact)
                   ##1 r.ctrl.comp_en |-> !primary_below_limit_n_out)
    else $error("below-limit flag not asserted");

  chk_secondary_flag :
  assert property ((accept_result && result_in.sec_out
                    && !result_in.prim_low && !result_in.prim_high
                    && !result_in.overload && !result_in.no_contact
                    && (result_in.bin >= 4'h1) && (result_in.bin <= 4'h9))
                   ##1 r.ctrl.comp_en |-> !secondary_out_of_limit_n_out)
    else $error("secondary flag not asserted");

  chk_low_value :
  assert property ((accept_result && lowc_hit) ##1 r.ctrl.comp_en
                   |-> !low_value_or_open_contact_n_out)
    else $error("low-value flag missing at threshold");

  chk_ready_idle :
  assert property (r.ctrl.comp_en && r.ctrl.ext_mode
                   && (r.st == handler_port_pkg::ST_IDLE)
                   |-> !trigger_acceptable_n_out)
    else $error("trigger-acceptable missing while idle");

  chk_ready_internal :
  assert property (!r.ctrl.ext_mode |-> trigger_acceptable_n_out)
    else $error("trigger-acceptable asserted in internal mode");

  chk_open_contact :
  assert property ((accept_result && result_in.no_contact)
                   ##1 r.ctrl.comp_en |-> !low_value_or_open_contact_n_out)
    else $error("low-value flag missing for open contact");

  chk_overrange_flag :
  assert property ((accept_result && result_in.overload) ##1 r.ctrl.comp_en
                   |-> !measurement_overrange_n_out
                       && class_line_n_out[handler_port_pkg::NO_MATCH_IX] == 1'b0)
    else $error("overload not reported");

  chk_keys_locked :
  assert property (!key_lock_n_in |=> panel_keys_out == '0)
    else $error("panel keys passed during lockout");

  chk_comp_off_quiet :
  assert property (!r.ctrl.comp_en |-> !analog_done_n_out
                   && !cycle_complete_n_out && (&class_line_n_out)
                   && primary_above_limit_n_out && primary_below_limit_n_out
                   && secondary_out_of_limit_n_out
                   && low_value_or_open_contact_n_out
                   && measurement_overrange_n_out && trigger_acceptable_n_out)
    else $error("lines driven while comparator is off");

  chk_analog_done :
  assert property ((analog_done_in && (r.st == handler_port_pkg::ST_MEASURE))
                   ##1 r.ctrl.comp_en |-> !analog_done_n_out)
    else $error("analog-done not asserted after analog end");

  chk_cycle_valid :
  assert property (r.ctrl.comp_en && !cycle_complete_n_out |-> r.have_result)
    else $error("cycle-complete asserted without a result");

  chk_hold_stable :
  assert property ((!accept_result && r.ctrl.comp_en) ##1 r.ctrl.comp_en
                   |-> $stable(class_line_n_out) && $stable(r.lowc_n))
    else $error("sort lines changed without a new result");

  chk_flags_stable :
  assert property ((!accept_result && r.ctrl.comp_en) ##1 r.ctrl.comp_en
                   |-> $stable(primary_above_limit_n_out)
                       && $stable(primary_below_limit_n_out)
                       && $stable(measurement_overrange_n_out))
    else $error("flag lines changed without a new result");

  chk_start_clears_done :
  assert property (measure_start_out && r.ctrl.comp_en
                   |-> cycle_complete_n_out && analog_done_n_out)
    else $error("done lines still low after a start");

  chk_busy_trigger :
  assert property ((r.st != handler_port_pkg::ST_IDLE) && r.ctrl.ext_mode
                   && $rose(external_trigger_in) |=> !measure_start_out)
    else $error("trigger taken while a measurement runs");

endmodule

`default_nettype wire

/* dv/handler_model.sv */
`timescale 1ns/10ps
`default_nettype none

module handler_model (
  input  wire logic        clk_in,      // Clock
  input  wire logic        go_in,       // Request a part test
  input  wire logic        done_n_in,   // Cycle complete, low
  input  wire logic [10:0] class_n_in,  // Class lines, low
  output logic             trigger_out, // Trigger pin
  output logic [10:0]      seen_out     // Class lines taken
);
  logic done_prev;
  int   hold;

  initial begin
    trigger_out = 1'b0;
    seen_out = 11'h7FF;
    done_prev = 1'b1;
    hold = 0;
  end

  // The trigger rests at ground and rises for a two cycle pulse.
  always @(posedge clk_in) begin
    if (go_in) begin
      trigger_out <= 1'b1;
      hold <= 2;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end else begin
      trigger_out <= 1'b0;
      hold <= 0;
    end
  end

  // Results are read only once the cycle is complete, never at analog done.
  always @(negedge clk_in) begin
    done_prev <= done_n_in;
    if (done_prev && !done_n_in) begin
      seen_out <= class_n_in;
    end
  end
endmodule

`default_nettype wire

/* dv/handler_port_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module handler_port_tb_top;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  handler_port_pkg::apb_req_t req = '0;
  handler_port_pkg::apb_rsp_t rsp;
  handler_port_pkg::meas_result_t res = '0;
  logic                       trig, start, irq, go = 1'b0;
  logic                       lock_n = 1'b1, adone = 1'b0, rvalid = 1'b0;
  logic [7:0]                 keys = 8'h00, keys_o;
  logic [23:0]                val = 24'h0003E8;
  logic [10:0]                cls_n, sink, seen;
  logic                       hi_n, lo_n, sec_n, rdy_n, lowc_n;
  logic                       over_n, ad_n, cc_n, err, s;
  logic [31:0]                rd;
  logic [4:0]                 fl [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  int                         err_count = 0;
  int                         checks_done = 0;

  always #20 clk = ~clk;

  handler_port uut (.core_clk_in(clk), .reset_in(rst), .apb_req_in(req),
    .apb_rsp_out(rsp), .external_trigger_in(trig), .key_lock_n_in(lock_n),
    .panel_keys_in(keys), .panel_keys_out(keys_o), .analog_done_in(adone),
    .result_valid_in(rvalid), .result_in(res), .measured_value_in(val),
    .range_full_in(24'h001388), .measure_start_out(start),
    .class_line_n_out(cls_n), .class_sink_out(sink),
    .primary_above_limit_n_out(hi_n), .primary_below_limit_n_out(lo_n),
    .secondary_out_of_limit_n_out(sec_n), .trigger_acceptable_n_out(rdy_n),
    .low_value_or_open_contact_n_out(lowc_n),
    .measurement_overrange_n_out(over_n), .analog_done_n_out(ad_n),
    .cycle_complete_n_out(cc_n), .irq_out(irq));

  handler_model hm (.clk_in(clk), .go_in(go), .done_n_in(cc_n),
    .class_n_in(cls_n), .trigger_out(trig), .seen_out(seen));

  task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
    checks_done++;
    if (sv !== ev) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, sv, ev);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    err_count++;
    $display("Error at %0t: wait timed out", $time);
    final_report();
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (n == 20) hang();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic meas(input handler_port_pkg::meas_result_t r,
                      input logic [23:0] v, input logic comp);
    int n;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (start === 1'b1) break;
    end
    if (n == 20) hang();
    @(posedge clk);
    adone <= 1'b1;
    @(posedge clk);
    adone <= 1'b0;
    @(negedge clk);
    chk(ad_n, 1'b0);
    chk(cc_n, comp);
    @(posedge clk);
    res <= r;
    val <= v;
    rvalid <= 1'b1;
    @(posedge clk);
    rvalid <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (cc_n === 1'b0) break;
    end
    if (n == 20) hang();
    @(negedge clk);
  endtask

  // Expected active-high class hit, one line for every outcome.
  task automatic check_out(input handler_port_pkg::meas_result_t r,
                           input logic [23:0] v, input logic aux);
    logic [10:0] h, hn;
    h = 11'h001 << (r.bin - 4'h1);
    if (r.sec_out) h = aux ? 11'h400 : 11'h200;
    if (r.overload || r.no_contact || r.prim_high || r.prim_low) h = 11'h200;
    hn = ~h;
    chk(cls_n, hn);
    chk(sink, h);
    chk(seen, hn);
    chk(hi_n, !r.prim_high);
    chk(lo_n, !r.prim_low);
    chk(sec_n, !r.sec_out);
    chk(lowc_n, !(r.no_contact || 32'(v) * 100 <= 50000));
    chk(over_n, !r.overload);
    chk(rdy_n, 1'b0);
    repeat (3) @(negedge clk);
    chk(cls_n, hn);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(cls_n, 11'h7FF);
    chk(ad_n, 1'b0);
    chk(cc_n, 1'b0);
    apb(1'b0, handler_port_pkg::CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, handler_port_pkg::LOWC_OFF, 32'h0000000A);
    apb(1'b1, handler_port_pkg::IRQ_MASK_OFF, 32'h00000002);
    apb(1'b1, handler_port_pkg::CTRL_OFF, 32'h00000003);
    // A measurement began in internal mode at reset; finish it first.
    @(posedge clk);
    res <= '{bin: 4'h1, default: 1'b0};
    rvalid <= 1'b1;
    @(posedge clk);
    rvalid <= 1'b0;
    repeat (3) @(posedge clk);
    for (int b = 1; b <= 9; b++) begin
      meas('{bin: 4'(b), default: 1'b0}, 24'h0003E8, 1'b1);
      check_out('{bin: 4'(b), default: 1'b0}, 24'h0003E8, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      meas({4'h5, fl[i]}, 24'h0003E8, 1'b1);
      check_out({4'h5, fl[i]}, 24'h0003E8, 1'b0);
    end
    meas('{bin: 4'h2, default: 1'b0}, 24'h000190, 1'b1);
    check_out('{bin: 4'h2, default: 1'b0}, 24'h000190, 1'b0);
    chk(irq, 1'b1);
    apb(1'b1, handler_port_pkg::IRQ_STAT_OFF, 32'h0000001F);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b1, handler_port_pkg::CTRL_OFF, 32'h00000007);
    meas({4'h3, 5'h04}, 24'h0003E8, 1'b1);
    check_out({4'h3, 5'h04}, 24'h0003E8, 1'b1);
    apb(1'b1, handler_port_pkg::CTRL_OFF, 32'h00000002);
    meas({4'h4, 5'h18}, 24'h0003E8, 1'b0);
    chk({cls_n, hi_n, lo_n, sec_n, lowc_n, over_n}, 16'hFFFF);
    chk({ad_n, cc_n}, 2'h0);
    @(posedge clk);
    lock_n <= 1'b0;
    keys <= 8'hA5;
    repeat (2) @(negedge clk);
    chk(keys_o, 8'h00);
    @(posedge clk);
    lock_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk(keys_o, 8'hA5);
    apb(1'b1, handler_port_pkg::CTRL_OFF, 32'h00000001);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      chk(rdy_n, 1'b1);
      s = start;
      @(posedge clk);
      rvalid <= s;
    end
    final_report();
  end
endmodule

`default_nettype wire
